/* File: include/mssp_pkg.sv */
/*
  Constants and carrier types for the motor starter protection supervisor.
  Assumes a 100 MHz ref_clk and settings held stable by the parameter store.
*/
package mssp_pkg;
  // Clock and second tick
  localparam int CLK_HZ = 100000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  // Percentage ranges
  localparam logic [7:0] UC_THR_MIN = 8'h14;
  localparam logic [7:0] UC_THR_MAX = 8'hBE;
  localparam logic [7:0] UC_THR_DEF = 8'h46;
  localparam logic [7:0] JOG_MIN = 8'h19;
  localparam logic [7:0] JOG_MAX = 8'h32;
  localparam logic [7:0] JOG_DEF = 8'h19;
  localparam logic [7:0] DCB_MIN = 8'h1E;
  localparam logic [7:0] DCB_MAX = 8'h32;
  localparam logic [7:0] DCB_DEF = 8'h1E;
  localparam logic [7:0] KICK_MIN = 8'h46;
  localparam logic [7:0] KICK_MAX = 8'h5A;
  localparam logic [7:0] KICK_DEF = 8'h46;
  // Second ranges, zero means off
  localparam logic [7:0] OC_TIME_MAX = 8'h14;
  localparam logic [7:0] UC_TIME_MAX = 8'hC8;
  localparam logic [7:0] DCB_TIME_MAX = 8'h0A;
  localparam logic [9:0] INHIBIT_MAX = 10'h3E7;
  localparam logic [9:0] INHIBIT_DEF = 10'h002;
  // Output function code that enables DC braking
  localparam logic [3:0] OUT_FN_DCB = 4'h3;
  // Rated voltage default index (380 V) and count of entries
  localparam logic [3:0] VOLT_IDX_DEF = 4'h3;
  localparam logic [3:0] VOLT_IDX_NUM = 4'hB;
  localparam logic [3:0] CUR_IDX_NUM = 4'hE;
  // Inside-delta scale 1.73 as 173/100, done as x*443>>8
  localparam logic [9:0] DELTA_MUL = 10'h1BB;
  localparam int DELTA_SHIFT = 8;

  typedef struct packed {
    logic [7:0] accel_ramp_time;
    logic [7:0] decel_ramp_time;
    logic [7:0] overcurrent_threshold;
    logic [7:0] overcurrent_duration;
    logic [7:0] undercurrent_threshold;
    logic [7:0] undercurrent_duration;
    logic [3:0] rated_current_setting;
    logic [3:0] rated_voltage_setting;
    logic inside_delta_select;
    logic phase_order_check;
    logic [7:0] jog_voltage_level;
    logic [7:0] dc_brake_time;
    logic [7:0] dc_brake_voltage;
    logic [9:0] restart_inhibit_interval;
    logic [7:0] kick_pulse_time;
    logic [7:0] kick_pulse_level;
    logic [3:0] output_function_select;
  } mssp_cfg_type;

  typedef struct packed {
    logic panel_start;
    logic panel_stop;
    logic start_stop_input_a;
    logic start_stop_input_b;
    logic serial_start;
    logic serial_stop;
    logic reverse;
    logic jog_input;
  } mssp_cmd_type;

  typedef struct packed {
    logic ramp_timeout_fault;
    logic undercurrent_fault;
    logic overcurrent_fault;
    logic phase_order_fault;
  } mssp_fault_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_KICK, ST_ACCEL, ST_FULL, ST_JOG, ST_DECEL, ST_BRAKE, ST_FAULT
  } mssp_state_type;
endpackage

/* File: rtl/mssp_top.sv */
/*
  Motor starter protection supervisor: start sequencing, jog, kick start,
  DC braking gate, restart inhibit and over/undercurrent trips.
  Assumes settings held stable by the parameter store, current and
  voltage samples on ref_clk, and ramp_done from the firing logic.
*/
`timescale 1ns/1ps
// Functional notes
// - Undercurrent watched only at full voltage.
// - Undercurrent threshold 20..190 percent, default 70.
// - Overcurrent time off or 1..20 s.
// - Undercurrent time off or 1..200 s.
// - Rated current base for all limits.
// - Inside delta scales base by 1.73.
// - Rated voltage list 220..575, default 380.
// - Phase check enabled allows only RST.
// - Phase order sampled once after reset.
// - Jog ramps to jog level while closed.
// - Jog limited to accel time, then fault.
// - Jog level 25..50 percent, default 25.
// - DC brake only function 3, standard wiring.
// - Thermal protection off during DC brake.
// - Brake level 30..50 percent, default 30.
// - Starts refused until inhibit interval elapses.
// - Inhibit counting begins at stop command.
// - Jog ignores the inhibit timer.
// - Reversal start waits for inhibit interval.
// - Kick pulse then normal acceleration ramp.
// - Undercurrent fault after duration below threshold.
// - Overcurrent trips output after duration.
// - Kick start blocks starting current limit.
// - Kick level minimum and default 70 percent.
module mssp_top
  import mssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire mssp_cfg_type cfg,
  input wire mssp_cmd_type cmd,
  input wire logic kick_enable,
  input wire logic [11:0] load_current,
  input wire logic phase_seq_rst,
  input wire logic ramp_done,
  output logic output_enable,
  output logic [7:0] voltage_target,
  output logic current_limit_enable,
  output logic thermal_enable,
  output logic dc_brake_active,
  output logic start_inhibited,
  output logic [11:0] rated_current_base,
  output logic [9:0] rated_voltage,
  output mssp_fault_type faults,
  output mssp_state_type state
);

  //////////////////////////////////////////////////////////////////////////
  // Rating lists; an index past the end is guarded where it is read
  localparam logic [11:0] CUR_LIST [14] = '{12'h078, 12'h0AA, 12'h0CD, 12'h0FF, 12'h122,
    12'h154, 12'h19A, 12'h1DB, 12'h244, 12'h29E, 12'h320, 12'h3B6, 12'h44C, 12'h578};
  localparam logic [9:0] VOLT_LIST [11] = '{10'h0DC, 10'h0E6, 10'h0F0, 10'h17C, 10'h190,
    10'h19F, 10'h1B8, 10'h1CC, 10'h1E0, 10'h20D, 10'h23F};

  // Clamp a percent into its range
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Percent of base current: base*pct/100, pct scaled as pct*41>>12
  function automatic logic [11:0] pct_of(input logic [11:0] base, input logic [7:0] pct);
    logic [25:0] prod;
    prod = 26'(base) * 26'(pct) * 26'd41;
    return prod[23:12];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // One second tick; a tick period is too long to step in simulation
  logic [26:0] tick_cnt;
  logic tick;
  always_ff @(posedge ref_clk)
  begin
    if (rst || tick_cnt == 27'(TICK_CYCLES - 1))
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 27'd1;
  end
  assign tick = (tick_cnt == 27'(TICK_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for digital inputs and phase detector
  logic [4:0] sync1, sync2, sync3;
  always_ff @(posedge ref_clk)
  begin
    sync1 <= {cmd.start_stop_input_a, cmd.start_stop_input_b, cmd.jog_input,
              cmd.reverse, phase_seq_rst};
    sync2 <= sync1;
    sync3 <= sync2;
  end
  logic [4:0] pins;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pins <= '0;
    else
      pins <= (sync2 == sync3) ? sync3 : pins;
  end
  wire din_a = pins[4];
  wire din_b = pins[3];
  wire jog_pin = pins[2];
  wire rev_pin = pins[1];
  wire phase_ok_pin = pins[0];

  //////////////////////////////////////////////////////////////////////////
  // Bases and levels
  // base from rating list
  wire [11:0] own_base = (cfg.rated_current_setting < CUR_IDX_NUM) ?
                         CUR_LIST[cfg.rated_current_setting] : CUR_LIST[0];
  wire [21:0] delta_prod = 22'(own_base) * 22'(DELTA_MUL);
  wire [11:0] next_base = cfg.inside_delta_select ? delta_prod[19:8] : own_base;
  // rated voltage from list, default entry outside list
  wire [3:0] volt_idx = (cfg.rated_voltage_setting < VOLT_IDX_NUM) ?
                        cfg.rated_voltage_setting : VOLT_IDX_DEF;
  wire [7:0] uc_pct = clamp8(cfg.undercurrent_threshold, UC_THR_MIN, UC_THR_MAX);
  wire [7:0] jog_lvl = clamp8(cfg.jog_voltage_level, JOG_MIN, JOG_MAX);
  wire [7:0] dcb_lvl = clamp8(cfg.dc_brake_voltage, DCB_MIN, DCB_MAX);
  wire [7:0] kick_lvl = clamp8(cfg.kick_pulse_level, KICK_MIN, KICK_MAX);
  wire [11:0] uc_amps = pct_of(next_base, uc_pct);
  wire [11:0] oc_amps = pct_of(next_base, cfg.overcurrent_threshold);
  wire [7:0] oc_lim = (cfg.overcurrent_duration > OC_TIME_MAX) ? OC_TIME_MAX :
                      cfg.overcurrent_duration;
  wire [7:0] uc_lim = (cfg.undercurrent_duration > UC_TIME_MAX) ? UC_TIME_MAX :
                      cfg.undercurrent_duration;
  wire [7:0] brk_lim = (cfg.dc_brake_time > DCB_TIME_MAX) ? DCB_TIME_MAX :
                       cfg.dc_brake_time;
  wire [9:0] inh_lim = (cfg.restart_inhibit_interval > INHIBIT_MAX) ? INHIBIT_MAX :
                       cfg.restart_inhibit_interval;

  //////////////////////////////////////////////////////////////////////////
  // Command decode
  logic din_a_q, rev_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      {din_a_q, rev_q} <= 2'b00;
    else
      {din_a_q, rev_q} <= {din_a, rev_pin};
  end
  // Input A is the start edge; input B low is the stop contact
  wire start_req = cmd.panel_start | cmd.serial_start | (din_a & ~din_a_q);
  wire stop_req = cmd.panel_stop | cmd.serial_stop | (din_a_q & ~din_a) | ~din_b;
  wire rev_req = rev_pin ^ rev_q;

  //////////////////////////////////////////////////////////////////////////
  // Phase order latch: only the first power-up activation samples
  logic phase_seen, phase_bad;
  wire start_ok;
  wire begin_power = (state == ST_IDLE) && ((start_req && start_ok) || jog_pin);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      {phase_seen, phase_bad} <= 2'b00;
    else if (begin_power && !phase_seen)
      {phase_seen, phase_bad} <= {1'b1, ~phase_ok_pin};
  end
  wire phase_block = cfg.phase_order_check &&
                     (phase_seen ? phase_bad : ~phase_ok_pin);

  //////////////////////////////////////////////////////////////////////////
  // Restart inhibit counter
  logic [9:0] inh_cnt;
  wire stop_event = stop_req && (state == ST_ACCEL || state == ST_FULL ||
                                 state == ST_KICK);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      inh_cnt <= '0;
    // counting starts at the stop command
    else if (stop_event || (rev_req && state != ST_IDLE))
      inh_cnt <= inh_lim;
    else if (tick && inh_cnt != 10'd0)
      inh_cnt <= inh_cnt - 10'd1;
  end
  // starts refused while counting; reversal too
  assign start_ok = (inh_cnt == 10'd0);

  //////////////////////////////////////////////////////////////////////////
  // State machine with a shared seconds timer
  mssp_state_type next_state;
  logic [7:0] sec_cnt, oc_cnt, uc_cnt;
  wire brake_allowed = (cfg.output_function_select == OUT_FN_DCB) &&
                       !cfg.inside_delta_select && (brk_lim != 8'd0);
  wire acc_expired = (sec_cnt >= cfg.accel_ramp_time);
  wire oc_trip = (oc_lim != 8'd0) && (oc_cnt >= oc_lim);
  wire uc_trip = (uc_lim != 8'd0) && (uc_cnt >= uc_lim);
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (phase_block && (start_req || jog_pin))
          next_state = ST_FAULT;
        else if (jog_pin)
          next_state = ST_JOG;
        else if (start_req && start_ok)
          next_state = kick_enable && cfg.kick_pulse_time != 8'd0 ? ST_KICK : ST_ACCEL;
      ST_KICK:
        if (stop_req)
          next_state = ST_IDLE;
        else if (sec_cnt >= cfg.kick_pulse_time)
          next_state = ST_ACCEL;
      ST_ACCEL:
        if (stop_req)
          next_state = (cfg.decel_ramp_time != 8'd0) ? ST_DECEL : ST_IDLE;
        else if (ramp_done)
          next_state = ST_FULL;
        else if (acc_expired)
          next_state = ST_FAULT;
      ST_FULL:
        if (oc_trip || uc_trip)
          next_state = ST_FAULT;
        else if (stop_req)
          next_state = (cfg.decel_ramp_time != 8'd0) ? ST_DECEL :
                       (brake_allowed ? ST_BRAKE : ST_IDLE);
      // jog holds while closed, decel ramp only if enabled
      // jog limited to the accel time
      ST_JOG:
        if (acc_expired)
          next_state = ST_FAULT;
        else if (!jog_pin)
          next_state = (cfg.decel_ramp_time != 8'd0) ? ST_DECEL : ST_IDLE;
      ST_DECEL:
        if (sec_cnt >= cfg.decel_ramp_time)
          next_state = brake_allowed ? ST_BRAKE : ST_IDLE;
      // braking only when allowed, for its time
      ST_BRAKE:
        if (sec_cnt >= brk_lim)
          next_state = ST_IDLE;
      ST_FAULT:
        next_state = ST_FAULT;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sec_cnt <= '0;
    else if (next_state != state)
      sec_cnt <= '0;
    else if (tick && sec_cnt != 8'hFF)
      sec_cnt <= sec_cnt + 8'd1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Over and undercurrent timers, counting only at full voltage
  always_ff @(posedge ref_clk)
  begin
    if (rst || state != ST_FULL)
      {oc_cnt, uc_cnt} <= '0;
    else
    begin
      if (load_current <= oc_amps)
        oc_cnt <= '0;
      else if (tick && oc_cnt != 8'hFF)
        oc_cnt <= oc_cnt + 8'd1;
      if (load_current >= uc_amps)
        uc_cnt <= '0;
      else if (tick && uc_cnt != 8'hFF)
        uc_cnt <= uc_cnt + 8'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs; faults stay until reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      faults <= '0;
      output_enable <= 1'b0;
      voltage_target <= '0;
      current_limit_enable <= 1'b0;
      thermal_enable <= 1'b1;
      dc_brake_active <= 1'b0;
      start_inhibited <= 1'b0;
      rated_current_base <= '0;
      rated_voltage <= '0;
    end
    else
    begin
      state <= next_state;
      // ramp timeout fault on accel or jog expiry
      if ((state == ST_ACCEL || state == ST_JOG) && next_state == ST_FAULT)
        faults.ramp_timeout_fault <= 1'b1;
      if (state == ST_FULL && oc_trip)
        faults.overcurrent_fault <= 1'b1;
      if (state == ST_FULL && uc_trip)
        faults.undercurrent_fault <= 1'b1;
      if (state == ST_IDLE && next_state == ST_FAULT)
        faults.phase_order_fault <= 1'b1;
      output_enable <= (next_state != ST_IDLE) && (next_state != ST_FAULT);
      voltage_target <= (next_state == ST_KICK) ? kick_lvl :
                        (next_state == ST_JOG) ? jog_lvl :
                        (next_state == ST_BRAKE) ? dcb_lvl :
                        (next_state == ST_IDLE || next_state == ST_FAULT) ? 8'h00 :
                        8'h64;
      // no current limit during kick start
      current_limit_enable <= (next_state == ST_ACCEL) && !kick_enable;
      thermal_enable <= (next_state != ST_BRAKE);
      dc_brake_active <= (next_state == ST_BRAKE);
      start_inhibited <= !start_ok;
      rated_current_base <= next_base;
      rated_voltage <= VOLT_LIST[volt_idx];
    end
  end

endmodule // mssp_top

/* File: verif/mssp_sva.sv */
/*
  Port checker for mssp_top.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module mssp_sva
  import mssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire mssp_cfg_type cfg,
  input wire logic kick_enable,
  input wire logic output_enable,
  input wire logic [7:0] voltage_target,
  input wire logic current_limit_enable,
  input wire logic thermal_enable,
  input wire logic dc_brake_active,
  input wire logic start_inhibited,
  input wire mssp_fault_type faults,
  input wire mssp_state_type state
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // kick blocks limit
  chk_kick_no_limit: assert property
    (state == ST_ACCEL && kick_enable && $past(kick_enable) |-> !current_limit_enable)
    else $error("Current limit active with kick start");
  chk_brake_gate: assert property
    (dc_brake_active |-> cfg.output_function_select == OUT_FN_DCB && !cfg.inside_delta_select)
    else $error("DC brake outside its selection");
  chk_brake_thermal: assert property
    (dc_brake_active |-> !thermal_enable)
    else $error("Thermal protection active in DC brake");
  chk_uc_off_quiet: assert property
    ($rose(faults.undercurrent_fault) |-> cfg.undercurrent_duration != 8'h00)
    else $error("Undercurrent fault with time off");
  chk_oc_trip_off: assert property
    ($rose(faults.overcurrent_fault) |-> state == ST_FAULT && !output_enable)
    else $error("Overcurrent fault without shutdown");
  chk_jog_level: assert property
    (state == ST_JOG && $past(state) == ST_JOG |-> voltage_target == cfg.jog_voltage_level)
    else $error("Jog level wrong");
  chk_kick_level: assert property
    (state == ST_KICK && $past(state) == ST_KICK |-> voltage_target == cfg.kick_pulse_level)
    else $error("Kick level wrong");
  chk_start_refused: assert property
    (state == ST_IDLE && start_inhibited ##1 start_inhibited |-> state != ST_ACCEL
      && state != ST_KICK)
    else $error("Start taken while inhibited");
  chk_stop_inhibit: assert property
    (!$past(rst) && $past(state) == ST_FULL && state == ST_IDLE
      && cfg.restart_inhibit_interval != 10'h000 |=> start_inhibited)
    else $error("Inhibit not started at stop");
  chk_phase_gate: assert property
    ($rose(faults.phase_order_fault) |-> cfg.phase_order_check)
    else $error("Phase fault with check disabled");
endmodule // mssp_sva

bind mssp_top mssp_sva u_sva (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .kick_enable(kick_enable),
  .output_enable(output_enable), .voltage_target(voltage_target), .state(state),
  .current_limit_enable(current_limit_enable), .thermal_enable(thermal_enable),
  .dc_brake_active(dc_brake_active), .start_inhibited(start_inhibited), .faults(faults));

/* File: verif/mssp_cmd_source.sv */
/*
  Command source model: operator panel, digital pins and serial master.
  Assumes one request code per cycle from the bench, 0 meaning none.
*/
`timescale 1ns/1ps
module mssp_cmd_source
  import mssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [2:0] op,
  output mssp_cmd_type cmd
);
  logic jog = 1'b0;
  logic rev = 1'b0;
  logic [3:0] pulse = 4'h0;
  // Stop pin held inactive so it never masks a start
  assign cmd = '{panel_start: pulse[0], panel_stop: pulse[1], start_stop_input_a: 1'b0,
    start_stop_input_b: 1'b1, serial_start: pulse[2], serial_stop: pulse[3],
    reverse: rev, jog_input: jog};
  // Panel and serial pulses last one cycle, pins hold
  always_ff @(posedge ref_clk)
  begin
    pulse <= {op == 3'h4, op == 3'h3, op == 3'h2, op == 3'h1};
    jog <= (op == 3'h5) ? 1'b1 : ((op == 3'h6) ? 1'b0 : jog);
    rev <= rev ^ (op == 3'h7);
  end
endmodule // mssp_cmd_source

/* File: verif/motor_starter_protection_supervisor_tb.sv */
/*
  Self-checking bench for mssp_top with the command source model.
  Assumes 100 MHz ref_clk; second-long timers are not run out.
*/
`timescale 1ns/1ps
module motor_starter_protection_supervisor_tb
  import mssp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  mssp_cfg_type cfg;
  mssp_cmd_type cmd;
  logic kick_enable, phase_seq_rst, ramp_done, output_enable, current_limit_enable;
  logic thermal_enable, dc_brake_active, start_inhibited;
  logic [11:0] load_current, rated_current_base;
  logic [7:0] voltage_target;
  logic [9:0] rated_voltage;
  logic [2:0] op;
  mssp_fault_type faults;
  mssp_state_type state;
  int miscompares = 0;
  int n_tests = 0;
  int cur_a[14] = '{120, 170, 205, 255, 290, 340, 410, 475, 580, 670, 800, 950, 1100, 1400};
  int volt_v[11] = '{220, 230, 240, 380, 400, 415, 440, 460, 480, 525, 575};
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #5 ref_clk = ~ref_clk;
  mssp_cmd_source u_src (.ref_clk(ref_clk), .op(op), .cmd(cmd));
  mssp_top DUT (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .cmd(cmd), .kick_enable(kick_enable),
    .load_current(load_current), .phase_seq_rst(phase_seq_rst), .ramp_done(ramp_done),
    .output_enable(output_enable), .voltage_target(voltage_target),
    .current_limit_enable(current_limit_enable), .thermal_enable(thermal_enable),
    .dc_brake_active(dc_brake_active), .start_inhibited(start_inhibited),
    .rated_current_base(rated_current_base), .rated_voltage(rated_voltage),
    .faults(faults), .state(state));
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic send(input logic [2:0] c);
    @(posedge ref_clk);
    op <= c;
    @(posedge ref_clk);
    op <= 3'h0;
  endtask
  // Bounded wait; a missed state closes the run
  task automatic wait_state(input mssp_state_type s);
    int i;
    i = 0;
    while (state !== s && i < 20)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk("state", s, state);
    if (state !== s)
      print_verdict();
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    ramp_done <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic run_full();
    send(3'h1);
    wait_state(ST_ACCEL);
    chk("limit", 1, current_limit_enable);
    chk("output_enable", 1, output_enable);
    @(posedge ref_clk);
    ramp_done <= 1'b1;
    wait_state(ST_FULL);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cfg = '0;
    cfg.accel_ramp_time = 8'h14;
    cfg.overcurrent_threshold = 8'h78;
    cfg.undercurrent_threshold = UC_THR_DEF;
    cfg.rated_voltage_setting = VOLT_IDX_DEF;
    cfg.jog_voltage_level = JOG_DEF;
    cfg.dc_brake_voltage = DCB_DEF;
    cfg.restart_inhibit_interval = INHIBIT_DEF;
    cfg.kick_pulse_time = 8'h01;
    cfg.kick_pulse_level = KICK_DEF;
    {kick_enable, ramp_done, op} = '0;
    phase_seq_rst = 1'b1;
    load_current = 12'h050;
    do_reset();
    #1;
    chk("output_enable", 0, output_enable);
    chk("thermal_enable", 1, thermal_enable);
    chk("faults", 0, faults);
    $display("reset test done");
    // Rating rows: index in, amps and volts out
    for (int i = 0; i < 14; i++)
    begin
      @(posedge ref_clk);
      cfg.rated_current_setting <= 4'(i);
      cfg.inside_delta_select <= i[0];
      cfg.rated_voltage_setting <= 4'(i);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("base", i[0] ? (cur_a[i] * 443) >> 8 : cur_a[i], rated_current_base);
      chk("volts", i < 11 ? volt_v[i] : 380, rated_voltage);
    end
    cfg.inside_delta_select <= 1'b0;
    $display("rating rows done");
    do_reset();
    run_full();
    chk("limit off", 0, current_limit_enable);
    send(3'h2);
    ramp_done <= 1'b0;
    wait_state(ST_IDLE);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("inhibit", 1, start_inhibited);
    send(3'h3);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("refused", ST_IDLE, state);
    send(3'h5);
    wait_state(ST_JOG);
    chk("jog level", JOG_DEF, voltage_target);
    send(3'h6);
    wait_state(ST_IDLE);
    $display("inhibit and jog test done");
    do_reset();
    run_full();
    send(3'h7);
    repeat (8) @(posedge ref_clk);
    #1;
    chk("reverse inhibit", 1, start_inhibited);
    do_reset();
    kick_enable <= 1'b1;
    send(3'h1);
    wait_state(ST_KICK);
    chk("kick level", KICK_DEF, voltage_target);
    chk("kick limit", 0, current_limit_enable);
    do_reset();
    cfg.kick_pulse_time <= 8'h00;
    send(3'h1);
    wait_state(ST_ACCEL);
    chk("kick accel limit", 0, current_limit_enable);
    $display("reverse and kick test done");
    do_reset();
    kick_enable <= 1'b0;
    cfg.output_function_select <= OUT_FN_DCB;
    cfg.dc_brake_time <= 8'h01;
    run_full();
    send(3'h2);
    wait_state(ST_BRAKE);
    chk("thermal", 0, thermal_enable);
    chk("brake level", DCB_DEF, voltage_target);
    chk("brake on", 1, dc_brake_active);
    do_reset();
    cfg.inside_delta_select <= 1'b1;
    run_full();
    send(3'h4);
    wait_state(ST_IDLE);
    chk("brake", 0, dc_brake_active);
    $display("brake test done");
    do_reset();
    cfg.phase_order_check <= 1'b1;
    phase_seq_rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    send(3'h1);
    wait_state(ST_FAULT);
    chk("phase fault", 1, faults.phase_order_fault);
    $display("phase test done");
    print_verdict();
  end
endmodule // motor_starter_protection_supervisor_tb
